// ---- design/pcdao_consts.svh ----
// Constants for the port C/D alternate function override block.
// Assumes a 25 MHz system clock; included by the package and modules.
// Functional notes
// (RULE1) Async timer select frees C6, overrides off
// (RULE2) C7/C6 carry oscillator, no digital input
// (RULE3) Test port: C5 pull-up on, input, data in
// (RULE4) C4 drives test data only while shifting
// (RULE5) C3 pull-up on, input, mode select
// (RULE6) C2 is test clock, pull-up on
// (RULE7) Two-wire data line open drain, low
// (RULE8) Two-wire clock line open drain, low
// (RULE9) Two-wire pull-ups follow data bit, gated
// (RULE10) Two-wire inputs filter spikes under 50 ns
// (RULE11) Timer2 compare drives D7 when output
// (RULE12) Timer1 compares override D5, D4 values
// (RULE13) D6 input feeds timer1 capture
// (RULE14) External interrupt enable forces input enable
// (RULE15) Transmitter forces D1 output with data
// (RULE16) Receiver forces D0 input, feeds receiver
// (RULE17) Receiver pin pull-up follows data bit
// (RULE18) Global pull-up disable kills all pull-ups; test port pull-ups on C5, C3, C2 stay on
// (RULE19) Active override enable selects override value
`ifndef PCDAO_CONSTS_SVH
`define PCDAO_CONSTS_SVH
`define PCDAO_CLK_MHZ 25
`define PCDAO_SPIKE_NS 50
// Filter needs more than spike length of stable input: ceil(50*25/1000)
`define PCDAO_SPIKE_CYC ((`PCDAO_SPIKE_NS * `PCDAO_CLK_MHZ + 999) / 1000)
`define PCDAO_FILT_W 2
`define PCDAO_PIN_C7 3'd7
`define PCDAO_PIN_C6 3'd6
`define PCDAO_PIN_C5 3'd5
`define PCDAO_PIN_C4 3'd4
`define PCDAO_PIN_C3 3'd3
`define PCDAO_PIN_C2 3'd2
`define PCDAO_PIN_C1 3'd1
`define PCDAO_PIN_C0 3'd0
`endif

// ---- design/pcdao_pkg.sv ----
// Types for the port C/D alternate function override block.
// Assumes pcdao_consts.svh is on the include path.
`include "pcdao_consts.svh"
package pcdao_pkg;
  typedef logic [7:0] pcdao_byte_t;
  typedef logic [`PCDAO_FILT_W-1:0] pcdao_cnt_t;
  typedef enum logic [1:0] {
    PCDAO_FILT_STABLE,
    PCDAO_FILT_CHANGE
  } pcdao_filt_state_t;
endpackage

// ---- design/pcdao_spike_filter.sv ----
// Spike filter for one two-wire input line.
// Assumes input already synchronous to clk_sys_in.
`timescale 1ns/1ns
`include "pcdao_consts.svh"
module pcdao_spike_filter (
  input wire logic clk_sys_in, // System clock
  input wire logic rst_b_in, // Async reset, active low
  input wire logic raw_in, // Unfiltered line level
  output logic clean_out // Filtered line level
);
  import pcdao_pkg::*;

  pcdao_filt_state_t state;
  pcdao_cnt_t count;

  // (RULE10) accept only held levels
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= PCDAO_FILT_STABLE;
      count <= '0;
      clean_out <= 1'b1;
    end else begin
      case (state)
        PCDAO_FILT_STABLE: begin
          count <= '0;
          if (raw_in != clean_out) begin
            state <= PCDAO_FILT_CHANGE;
          end
        end
        PCDAO_FILT_CHANGE: begin
          if (raw_in == clean_out) begin
            state <= PCDAO_FILT_STABLE;
            count <= '0;
          end else if (count == pcdao_cnt_t'(`PCDAO_SPIKE_CYC - 1)) begin
            clean_out <= raw_in;
            state <= PCDAO_FILT_STABLE;
            count <= '0;
          end else begin
            count <= count + pcdao_cnt_t'(1);
          end
        end
        default: begin
          state <= PCDAO_FILT_STABLE;
          count <= '0;
        end
      endcase
    end
  end

  property p_filt_hold;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    $changed(clean_out) |-> $past(raw_in) == clean_out && $past(raw_in, 2) == clean_out;
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter passed a short pulse"); // RULE10
endmodule

// ---- design/pcdao_top.sv ----
// Port C/D alternate function override: per-pin pull-up, direction,
// output value and input enable, plus inputs routed to peripherals.
// Assumes port registers and peripherals are synchronous to clk_sys_in.
`timescale 1ns/1ns
`include "pcdao_consts.svh"
module pcdao_top (
  input wire logic clk_sys_in, // System clock
  input wire logic rst_b_in, // Async reset, active low
  input wire pcdao_pkg::pcdao_byte_t portc_data_in, // Port C data register
  input wire pcdao_pkg::pcdao_byte_t portc_dir_in, // Port C direction register
  input wire pcdao_pkg::pcdao_byte_t portd_data_in, // Port D data register
  input wire pcdao_pkg::pcdao_byte_t portd_dir_in, // Port D direction register
  input wire pcdao_pkg::pcdao_byte_t portc_pin_in, // Port C pad levels
  input wire pcdao_pkg::pcdao_byte_t portd_pin_in, // Port D pad levels
  input wire logic global_pullup_disable_in, // Global pull-up disable
  input wire logic timer2_async_select_in, // Timer2 async clock select
  input wire logic test_port_enable_in, // Test port enable
  input wire logic tap_shift_in, // TAP in Shift-IR or Shift-DR
  input wire logic tap_data_out_in, // Test data from TAP
  input wire logic two_wire_enable_in, // Two-wire enable
  input wire logic two_wire_data_drive_in, // Two-wire unit pulls data low
  input wire logic two_wire_clock_drive_in, // Two-wire unit pulls clock low
  input wire logic timer2_compare_enable_in, // Timer2 compare output enable
  input wire logic timer2_compare_out_in, // Timer2 compare value
  input wire logic timer1_compare_a_enable_in, // Timer1 compare A enable
  input wire logic timer1_compare_out_a_in, // Timer1 compare A value
  input wire logic timer1_compare_b_enable_in, // Timer1 compare B enable
  input wire logic timer1_compare_out_b_in, // Timer1 compare B value
  input wire logic ext_irq_one_enable_in, // External interrupt 1 enable
  input wire logic ext_irq_zero_enable_in, // External interrupt 0 enable
  input wire logic serial_transmitter_enable_in, // Serial transmitter enable
  input wire logic serial_tx_data_in, // Serial transmit data
  input wire logic serial_receiver_enable_in, // Serial receiver enable
  output pcdao_pkg::pcdao_byte_t portc_pullup_out, // Port C pull-up on
  output pcdao_pkg::pcdao_byte_t portc_oe_out, // Port C driver enable
  output pcdao_pkg::pcdao_byte_t portc_value_out, // Port C driven value
  output pcdao_pkg::pcdao_byte_t portc_input_en_out, // Port C digital input enable
  output pcdao_pkg::pcdao_byte_t portc_digital_out, // Port C digital input values
  output pcdao_pkg::pcdao_byte_t portd_pullup_out, // Port D pull-up on
  output pcdao_pkg::pcdao_byte_t portd_oe_out, // Port D driver enable
  output pcdao_pkg::pcdao_byte_t portd_value_out, // Port D driven value
  output pcdao_pkg::pcdao_byte_t portd_input_en_out, // Port D digital input enable
  output pcdao_pkg::pcdao_byte_t portd_digital_out, // Port D digital input values
  output logic timer_osc_input_pin_out, // Oscillator input analog path select
  output logic timer_osc_output_pin_out, // Oscillator output analog path select
  output logic tap_data_in_out, // Serial test data into TAP
  output logic tap_mode_select_out, // Mode select into TAP
  output logic tap_clock_out, // Test clock, clocks all TAP logic
  output logic two_wire_data_in_out, // Filtered two-wire data
  output logic two_wire_clock_in_out, // Filtered two-wire clock
  output logic timer1_capture_in_out, // Timer1 capture trigger
  output logic ext_irq_one_in_out, // External interrupt 1 level
  output logic ext_irq_zero_in_out, // External interrupt 0 level
  output logic serial_rx_data_out // Serial receive data
);
  import pcdao_pkg::*;

  typedef struct packed {
    logic pu_oe;
    logic pu_ov;
    logic dd_oe;
    logic dd_ov;
    logic pv_oe;
    logic pv_ov;
    logic die_oe;
    logic die_ov;
  } pcdao_ovr_t;

  pcdao_ovr_t ovr_c [8];
  pcdao_ovr_t ovr_d [8];
  pcdao_byte_t next_c_pu, next_c_oe, next_c_val, next_c_die;
  pcdao_byte_t next_d_pu, next_d_oe, next_d_val, next_d_die;
  logic global_pullup_disable;

  // Pull-up from port registers: data set, direction input, not disabled
  function automatic logic base_pullup(input logic data, input logic dir, input logic dis);
    base_pullup = data & ~dir & ~dis;
  endfunction

  // (RULE19) Selects override over register value
  function automatic logic pick(input logic en, input logic ov, input logic reg_v);
    pick = en ? ov : reg_v;
  endfunction

  assign global_pullup_disable = global_pullup_disable_in;

  // Port C override table
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ovr_c[i] = '0;
    end
    // (RULE1) (RULE2) Oscillator pins
    ovr_c[7].pu_oe = timer2_async_select_in;
    ovr_c[7].dd_oe = timer2_async_select_in;
    ovr_c[7].die_oe = timer2_async_select_in;
    ovr_c[6].pu_oe = timer2_async_select_in;
    ovr_c[6].dd_oe = timer2_async_select_in;
    ovr_c[6].die_oe = timer2_async_select_in;
    // (RULE3) Test data in pin
    ovr_c[5].pu_oe = test_port_enable_in;
    ovr_c[5].pu_ov = 1'b1;
    ovr_c[5].dd_oe = test_port_enable_in;
    ovr_c[5].die_oe = test_port_enable_in;
    // (RULE4) Test data out pin
    ovr_c[4].pu_oe = test_port_enable_in;
    ovr_c[4].dd_oe = test_port_enable_in;
    ovr_c[4].dd_ov = tap_shift_in;
    ovr_c[4].pv_oe = test_port_enable_in;
    ovr_c[4].pv_ov = tap_data_out_in;
    ovr_c[4].die_oe = test_port_enable_in;
    // (RULE5) Mode select pin
    ovr_c[3].pu_oe = test_port_enable_in;
    ovr_c[3].pu_ov = 1'b1;
    ovr_c[3].dd_oe = test_port_enable_in;
    ovr_c[3].die_oe = test_port_enable_in;
    // (RULE6) Test clock pin
    ovr_c[2].pu_oe = test_port_enable_in;
    ovr_c[2].pu_ov = 1'b1;
    ovr_c[2].dd_oe = test_port_enable_in;
    ovr_c[2].die_oe = test_port_enable_in;
    // (RULE7) (RULE9) Two-wire data line
    ovr_c[1].pu_oe = two_wire_enable_in;
    ovr_c[1].pu_ov = portc_data_in[1] & ~global_pullup_disable;
    ovr_c[1].dd_oe = two_wire_enable_in;
    ovr_c[1].dd_ov = two_wire_data_drive_in;
    ovr_c[1].pv_oe = two_wire_enable_in;
    // (RULE8) (RULE9) Two-wire clock line
    ovr_c[0].pu_oe = two_wire_enable_in;
    ovr_c[0].pu_ov = portc_data_in[0] & ~global_pullup_disable;
    ovr_c[0].dd_oe = two_wire_enable_in;
    ovr_c[0].dd_ov = two_wire_clock_drive_in;
    ovr_c[0].pv_oe = two_wire_enable_in;
  end

  // Port D override table
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ovr_d[i] = '0;
    end
    // (RULE11) Timer2 compare value; direction stays with software
    ovr_d[7].pv_oe = timer2_compare_enable_in;
    ovr_d[7].pv_ov = timer2_compare_out_in;
    // (RULE12) Timer1 compare values
    ovr_d[5].pv_oe = timer1_compare_a_enable_in;
    ovr_d[5].pv_ov = timer1_compare_out_a_in;
    ovr_d[4].pv_oe = timer1_compare_b_enable_in;
    ovr_d[4].pv_ov = timer1_compare_out_b_in;
    // (RULE14) Keep interrupt pins visible
    ovr_d[3].die_oe = ext_irq_one_enable_in;
    ovr_d[3].die_ov = 1'b1;
    ovr_d[2].die_oe = ext_irq_zero_enable_in;
    ovr_d[2].die_ov = 1'b1;
    // (RULE15) Transmit pin
    ovr_d[1].pu_oe = serial_transmitter_enable_in;
    ovr_d[1].dd_oe = serial_transmitter_enable_in;
    ovr_d[1].dd_ov = 1'b1;
    ovr_d[1].pv_oe = serial_transmitter_enable_in;
    ovr_d[1].pv_ov = serial_tx_data_in;
    // (RULE16) (RULE17) Receive pin
    ovr_d[0].pu_oe = serial_receiver_enable_in;
    ovr_d[0].pu_ov = portd_data_in[0] & ~global_pullup_disable;
    ovr_d[0].dd_oe = serial_receiver_enable_in;
  end

  // Merge overrides with register-derived values
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // (RULE18) Register pull-ups gated by global disable; test port overrides are not
      next_c_pu[i] = pick(ovr_c[i].pu_oe, ovr_c[i].pu_ov,
                          base_pullup(portc_data_in[i], portc_dir_in[i], global_pullup_disable));
      next_c_oe[i] = pick(ovr_c[i].dd_oe, ovr_c[i].dd_ov, portc_dir_in[i]);
      next_c_val[i] = pick(ovr_c[i].pv_oe, ovr_c[i].pv_ov, portc_data_in[i]);
      next_c_die[i] = pick(ovr_c[i].die_oe, ovr_c[i].die_ov, 1'b1);
      next_d_pu[i] = pick(ovr_d[i].pu_oe, ovr_d[i].pu_ov,
                          base_pullup(portd_data_in[i], portd_dir_in[i], global_pullup_disable));
      next_d_oe[i] = pick(ovr_d[i].dd_oe, ovr_d[i].dd_ov, portd_dir_in[i]);
      next_d_val[i] = pick(ovr_d[i].pv_oe, ovr_d[i].pv_ov, portd_data_in[i]);
      next_d_die[i] = pick(ovr_d[i].die_oe, ovr_d[i].die_ov, 1'b1);
    end
  end

  // Pad controls, registered
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      portc_pullup_out <= 8'h00;
      portc_oe_out <= 8'h00;
      portc_value_out <= 8'h00;
      portc_input_en_out <= 8'hFF;
      portd_pullup_out <= 8'h00;
      portd_oe_out <= 8'h00;
      portd_value_out <= 8'h00;
      portd_input_en_out <= 8'hFF;
    end else begin
      portc_pullup_out <= next_c_pu;
      portc_oe_out <= next_c_oe;
      portc_value_out <= next_c_val;
      portc_input_en_out <= next_c_die;
      portd_pullup_out <= next_d_pu;
      portd_oe_out <= next_d_oe;
      portd_value_out <= next_d_val;
      portd_input_en_out <= next_d_die;
    end
  end

  // Digital input values, gated by input enable
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      portc_digital_out <= 8'h00;
      portd_digital_out <= 8'h00;
    end else begin
      // (RULE2) Disabled inputs read zero
      portc_digital_out <= portc_pin_in & next_c_die;
      portd_digital_out <= portd_pin_in & next_d_die;
    end
  end

  // Peripheral inputs
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      timer_osc_input_pin_out <= 1'b0;
      timer_osc_output_pin_out <= 1'b0;
      tap_data_in_out <= 1'b1;
      tap_mode_select_out <= 1'b1;
      tap_clock_out <= 1'b0;
      timer1_capture_in_out <= 1'b0;
      ext_irq_one_in_out <= 1'b1;
      ext_irq_zero_in_out <= 1'b1;
      serial_rx_data_out <= 1'b1;
    end else begin
      // (RULE2) Oscillator analog paths
      timer_osc_input_pin_out <= timer2_async_select_in;
      timer_osc_output_pin_out <= timer2_async_select_in;
      // (RULE3) (RULE5) Test inputs, idle high when disabled
      tap_data_in_out <= test_port_enable_in ? portc_pin_in[5] : 1'b1;
      tap_mode_select_out <= test_port_enable_in ? portc_pin_in[3] : 1'b1;
      // (RULE6) Test clock for TAP logic
      tap_clock_out <= test_port_enable_in & portc_pin_in[2];
      // (RULE13) Capture trigger from D6
      timer1_capture_in_out <= portd_pin_in[6];
      // (RULE14) Interrupt pins always sampled
      ext_irq_one_in_out <= portd_pin_in[3];
      ext_irq_zero_in_out <= portd_pin_in[2];
      // (RULE16) Receive data
      serial_rx_data_out <= serial_receiver_enable_in ? portd_pin_in[0] : 1'b1;
    end
  end

  // (RULE10) Two-wire input filters
  pcdao_spike_filter u_sda_filt (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .raw_in(portc_pin_in[1]),
    .clean_out(two_wire_data_in_out)
  );

  pcdao_spike_filter u_scl_filt (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .raw_in(portc_pin_in[0]),
    .clean_out(two_wire_clock_in_out)
  );

  property p_osc_pins;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    timer2_async_select_in |=> !portc_pullup_out[6] && !portc_oe_out[6]
      && !portc_input_en_out[6] && !portc_input_en_out[7];
  endproperty
  a_osc_pins: assert property (p_osc_pins) else $error("oscillator pin not detached"); // RULE1

  property p_osc_no_digital;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    timer2_async_select_in |=> portc_digital_out[7:6] == 2'b00;
  endproperty
  a_osc_no_digital: assert property (p_osc_no_digital) else $error("oscillator digital leak"); // RULE2

  property p_tdi;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    test_port_enable_in |=> portc_pullup_out[5] && !portc_oe_out[5] && !portc_input_en_out[5];
  endproperty
  a_tdi: assert property (p_tdi) else $error("test data in pin wrong"); // RULE3

  property p_tdo;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    test_port_enable_in |=> portc_oe_out[4] == $past(tap_shift_in) && !portc_pullup_out[4]
      && portc_value_out[4] == $past(tap_data_out_in);
  endproperty
  a_tdo: assert property (p_tdo) else $error("test data out pin wrong"); // RULE4

  property p_tms;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    test_port_enable_in |=> portc_pullup_out[3] && !portc_oe_out[3]
      && tap_mode_select_out == $past(portc_pin_in[3]);
  endproperty
  a_tms: assert property (p_tms) else $error("mode select pin wrong"); // RULE5

  property p_tck;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    test_port_enable_in |=> portc_pullup_out[2] && tap_clock_out == $past(portc_pin_in[2]);
  endproperty
  a_tck: assert property (p_tck) else $error("test clock pin wrong"); // RULE6

  property p_twi;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    two_wire_enable_in |=> portc_value_out[1:0] == 2'b00
      && portc_oe_out[1] == $past(two_wire_data_drive_in)
      && portc_oe_out[0] == $past(two_wire_clock_drive_in)
      && portc_pullup_out[1] == $past(portc_data_in[1] & ~global_pullup_disable_in);
  endproperty
  a_twi: assert property (p_twi) else $error("two-wire pins wrong"); // RULE7

  property p_pud;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (global_pullup_disable_in && !test_port_enable_in) |=> portd_pullup_out == 8'h00
      && portc_pullup_out[7:6] == 2'b00;
  endproperty
  a_pud: assert property (p_pud) else $error("pull-up on while disabled"); // RULE18

  property p_usart;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    (serial_transmitter_enable_in && serial_receiver_enable_in) |=> portd_oe_out[1:0] == 2'b10
      && portd_value_out[1] == $past(serial_tx_data_in) && !portd_pullup_out[1];
  endproperty
  a_usart: assert property (p_usart) else $error("serial pins wrong"); // RULE15

  property p_irq_die;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    ext_irq_one_enable_in |=> portd_input_en_out[3];
  endproperty
  a_irq_die: assert property (p_irq_die) else $error("interrupt input disabled"); // RULE14

  property p_twi_clk;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    two_wire_enable_in |=> portc_oe_out[0] == $past(two_wire_clock_drive_in)
      && !portc_value_out[0];
  endproperty
  a_twi_clk: assert property (p_twi_clk) else $error("two-wire clock pin wrong"); // RULE8

  property p_twi_pullup;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    two_wire_enable_in |=> portc_pullup_out[1:0]
      == $past(portc_data_in[1:0] & {2{~global_pullup_disable_in}});
  endproperty
  a_twi_pullup: assert property (p_twi_pullup) else $error("two-wire pull-up wrong"); // RULE9

  property p_t2_cmp;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    timer2_compare_enable_in |=> portd_value_out[7] == $past(timer2_compare_out_in)
      && portd_oe_out[7] == $past(portd_dir_in[7]);
  endproperty
  a_t2_cmp: assert property (p_t2_cmp) else $error("timer2 compare pin wrong"); // RULE11

  property p_rx;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    serial_receiver_enable_in |=> !portd_oe_out[0]
      && serial_rx_data_out == $past(portd_pin_in[0])
      && portd_pullup_out[0] == $past(portd_data_in[0] & ~global_pullup_disable_in);
  endproperty
  a_rx: assert property (p_rx) else $error("receive pin wrong"); // RULE16
endmodule

// ---- bench/pcdao_pad_model.sv ----
// Pad model for one 8-bit port: resolves each pin from the block's drive,
// an external driver and the pull-up. Assumes the shared system clock.
`timescale 1ns/1ns
module pcdao_pad_model (
  input wire logic clk_sys_in, // System clock
  input wire pcdao_pkg::pcdao_byte_t pullup_in, // Pull-up on
  input wire pcdao_pkg::pcdao_byte_t oe_in, // Block drives pin
  input wire pcdao_pkg::pcdao_byte_t value_in, // Block drive level
  input wire pcdao_pkg::pcdao_byte_t ext_en_in, // External driver active
  input wire pcdao_pkg::pcdao_byte_t ext_val_in, // External driver level
  output pcdao_pkg::pcdao_byte_t pin_out // Resolved pad level
);
  import pcdao_pkg::*;
  pcdao_byte_t last = 8'h00;
  // A floating pin shows the inverse of its last level, never a held value
  always_ff @(posedge clk_sys_in) begin
    last <= pin_out;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_in[i])
        pin_out[i] = value_in[i];
      else if (ext_en_in[i])
        pin_out[i] = ext_val_in[i];
      else if (pullup_in[i])
        pin_out[i] = 1'h1;
      else
        pin_out[i] = ~last[i];
    end
  end
endmodule

// ---- bench/pcdao_top_bench.sv ----
// Self-checking bench for the port C/D override block with pad models.
// Assumes outputs are registered one cycle after the inputs change.
`timescale 1ns/1ns
module pcdao_top_bench;
  import pcdao_pkg::*;
  logic clk_sys_in = 1'h0, rst_b_in = 1'h0, global_pullup_disable_in = 1'h0;
  logic timer2_async_select_in = 1'h0, test_port_enable_in = 1'h0, tap_shift_in = 1'h0;
  logic tap_data_out_in = 1'h0, two_wire_enable_in = 1'h0, two_wire_data_drive_in = 1'h0;
  logic two_wire_clock_drive_in = 1'h0, timer2_compare_enable_in = 1'h0;
  logic timer2_compare_out_in = 1'h0, timer1_compare_a_enable_in = 1'h0;
  logic timer1_compare_out_a_in = 1'h0, timer1_compare_b_enable_in = 1'h0;
  logic timer1_compare_out_b_in = 1'h0, ext_irq_one_enable_in = 1'h0;
  logic ext_irq_zero_enable_in = 1'h0, serial_transmitter_enable_in = 1'h0;
  logic serial_tx_data_in = 1'h0, serial_receiver_enable_in = 1'h0;
  pcdao_byte_t portc_data_in = 8'h00, portc_dir_in = 8'h00;
  pcdao_byte_t portd_data_in = 8'h00, portd_dir_in = 8'h00;
  pcdao_byte_t ext_en_c = 8'hFF, ext_val_c = 8'hFF, ext_en_d = 8'hFF, ext_val_d = 8'hFF;
  pcdao_byte_t portc_pin_in, portd_pin_in, portc_pullup_out, portc_oe_out, portc_value_out;
  pcdao_byte_t portc_input_en_out, portc_digital_out, portd_pullup_out, portd_oe_out;
  pcdao_byte_t portd_value_out, portd_input_en_out, portd_digital_out;
  logic timer_osc_input_pin_out, timer_osc_output_pin_out, tap_data_in_out;
  logic tap_mode_select_out, tap_clock_out, two_wire_data_in_out, two_wire_clock_in_out;
  logic timer1_capture_in_out, ext_irq_one_in_out, ext_irq_zero_in_out, serial_rx_data_out;
  int failures = 0;
  int comparisons = 0;

  pcdao_top pcdao_top_inst (.*);
  pcdao_pad_model pad_c_inst (.clk_sys_in(clk_sys_in), .pullup_in(portc_pullup_out),
    .oe_in(portc_oe_out), .value_in(portc_value_out), .ext_en_in(ext_en_c),
    .ext_val_in(ext_val_c), .pin_out(portc_pin_in));
  pcdao_pad_model pad_d_inst (.clk_sys_in(clk_sys_in), .pullup_in(portd_pullup_out),
    .oe_in(portd_oe_out), .value_in(portd_value_out), .ext_en_in(ext_en_d),
    .ext_val_in(ext_val_d), .pin_out(portd_pin_in));

  initial begin
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Lets the register stage and the pad feedback settle, samples mid-cycle
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask

  task automatic end_of_test;
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys_in);
    failures++;
    end_of_test();
  end

  initial begin
    wt(4);
    chk(portc_input_en_out, 8'hFF);
    chk({6'h00, tap_data_in_out, tap_clock_out}, 8'h02);
    repeat (12) @(posedge clk_sys_in);
    rst_b_in <= 1'h1;
    @(posedge clk_sys_in);
    portc_data_in <= 8'hA5;
    portc_dir_in <= 8'h0F;
    portd_data_in <= 8'h3C;
    portd_dir_in <= 8'hC3;
    wt(4);
    chk(portc_pullup_out, 8'hA0);
    chk(portc_oe_out, 8'h0F);
    chk(portc_value_out, 8'hA5);
    chk(portc_digital_out, 8'hF5);
    chk(portd_pullup_out, 8'h3C);
    @(posedge clk_sys_in);
    global_pullup_disable_in <= 1'h1;
    wt(4);
    chk(portc_pullup_out, 8'h00);
    chk(portd_pullup_out, 8'h00);
    $display("test 1 done: register paths");
    @(posedge clk_sys_in);
    global_pullup_disable_in <= 1'h0;
    timer2_async_select_in <= 1'h1;
    portc_dir_in <= 8'hCF;
    wt(4);
    chk(portc_pullup_out, 8'h20);
    chk(portc_oe_out, 8'h0F);
    chk(portc_input_en_out, 8'h3F);
    chk(portc_digital_out, 8'h35);
    chk({6'h00, timer_osc_input_pin_out, timer_osc_output_pin_out}, 8'h03);
    $display("test 2 done: oscillator pins");
    @(posedge clk_sys_in);
    timer2_async_select_in <= 1'h0;
    portc_data_in <= 8'hFF;
    portc_dir_in <= 8'h00;
    global_pullup_disable_in <= 1'h1;
    test_port_enable_in <= 1'h1;
    tap_shift_in <= 1'h1;
    tap_data_out_in <= 1'h1;
    ext_val_c <= 8'hD7;
    wt(4);
    chk(portc_pullup_out, 8'h2C);
    chk(portc_oe_out, 8'h10);
    chk(portc_value_out, 8'hFF);
    chk(portc_input_en_out, 8'hC3);
    chk({5'h00, tap_data_in_out, tap_mode_select_out, tap_clock_out}, 8'h01);
    @(posedge clk_sys_in);
    tap_shift_in <= 1'h0;
    wt(4);
    chk(portc_oe_out, 8'h00);
    $display("test 3 done: test port pins");
    @(posedge clk_sys_in);
    test_port_enable_in <= 1'h0;
    global_pullup_disable_in <= 1'h0;
    ext_val_c <= 8'hFF;
    ext_en_c <= 8'hFC;
    portc_data_in <= 8'h03;
    two_wire_enable_in <= 1'h1;
    two_wire_data_drive_in <= 1'h1;
    wt(6);
    chk(portc_pullup_out, 8'h03);
    chk(portc_oe_out, 8'h02);
    chk(portc_value_out, 8'h00);
    chk({6'h00, two_wire_data_in_out, two_wire_clock_in_out}, 8'h01);
    @(posedge clk_sys_in);
    two_wire_data_drive_in <= 1'h0;
    two_wire_clock_drive_in <= 1'h1;
    wt(6);
    chk(portc_oe_out, 8'h01);
    chk({6'h00, two_wire_data_in_out, two_wire_clock_in_out}, 8'h02);
    @(posedge clk_sys_in);
    two_wire_clock_drive_in <= 1'h0;
    wt(6);
    @(posedge clk_sys_in);
    two_wire_clock_drive_in <= 1'h1;
    @(posedge clk_sys_in);
    two_wire_clock_drive_in <= 1'h0;
    for (int i = 0; i < 6; i++) begin
      wt(0);
      chk({7'h00, two_wire_clock_in_out}, 8'h01);
      @(posedge clk_sys_in);
    end
    global_pullup_disable_in <= 1'h1;
    wt(4);
    chk(portc_pullup_out, 8'h00);
    $display("test 4 done: two-wire pins");
    @(posedge clk_sys_in);
    two_wire_enable_in <= 1'h0;
    global_pullup_disable_in <= 1'h0;
    ext_en_c <= 8'hFF;
    portd_data_in <= 8'h10;
    portd_dir_in <= 8'hB0;
    timer2_compare_enable_in <= 1'h1;
    timer2_compare_out_in <= 1'h1;
    timer1_compare_a_enable_in <= 1'h1;
    timer1_compare_out_a_in <= 1'h1;
    timer1_compare_b_enable_in <= 1'h1;
    ext_val_d <= 8'h77;
    ext_irq_one_enable_in <= 1'h1;
    ext_irq_zero_enable_in <= 1'h1;
    wt(4);
    chk(portd_value_out, 8'hA0);
    chk(portd_oe_out, 8'hB0);
    chk({7'h00, timer1_capture_in_out}, 8'h01);
    chk(portd_pullup_out, 8'h00);
    chk({6'h00, ext_irq_one_in_out, ext_irq_zero_in_out}, 8'h01);
    chk(portd_input_en_out, 8'hFF);
    chk(portd_digital_out, 8'hE7);
    $display("test 5 done: timer and interrupt pins");
    @(posedge clk_sys_in);
    timer2_compare_enable_in <= 1'h0;
    timer1_compare_a_enable_in <= 1'h0;
    timer1_compare_b_enable_in <= 1'h0;
    portd_data_in <= 8'h03;
    portd_dir_in <= 8'h01;
    serial_transmitter_enable_in <= 1'h1;
    serial_receiver_enable_in <= 1'h1;
    ext_val_d <= 8'hFE;
    wt(4);
    chk(portd_oe_out, 8'h02);
    chk(portd_value_out, 8'h01);
    chk(portd_pullup_out, 8'h01);
    chk({7'h00, serial_rx_data_out}, 8'h00);
    $display("test 6 done: serial pins");
    end_of_test();
  end
endmodule
